// File: imb_pkg.sv
// Shared register map, field positions, timing counts and states.
package imb_pkg;
	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [2:0] A_CON1 = 3'h0;
	localparam logic [2:0] A_CON2 = 3'h1;
	localparam logic [2:0] A_STAT = 3'h2;
	localparam logic [2:0] A_BAUD = 3'h3;
	localparam logic [2:0] A_BUF = 3'h4;
	localparam logic [2:0] A_FLAG = 3'h5;
	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int EN_BIT = 5;
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam int SEN_BIT = 0;
	localparam int PEN_BIT = 2;
	localparam int ACKDT_BIT = 5;
	localparam int ACKST_BIT = 6;
	localparam int GCEN_BIT = 7;
	localparam int BF_BIT = 0;
	localparam int SSEEN_BIT = 3;
	localparam int PSEEN_BIT = 4;
	localparam int SIF_BIT = 0;
	localparam int BCL_BIT = 1;
	localparam int WRITE_COLLISION_FLAG_BIT = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_ONE = 4'h1;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_HZ = 20_000_000;
	localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int TICK_W = 2;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_STA1 = 10'h002,
		S_STA2 = 10'h004,
		S_BLO = 10'h008,
		S_BWT = 10'h010,
		S_BHI = 10'h020,
		S_PLO = 10'h040,
		S_PWT = 10'h080,
		S_PHI = 10'h100,
		S_PREL = 10'h200
	} imb_state_t;
endpackage

// File: imb_baud_if.sv
// Control link between the sequencer and its baud generator.
interface imb_baud_if;
	logic load;
	logic [6:0] reload;
	logic done;
	modport ctl (output load, output reload, input done);
	modport gen (input load, input reload, output done);
endinterface

// File: imb_sync.sv
// Two-stage synchronizer for the sampled bus lines.
module imb_sync (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [1:0] i_async,
	output logic [1:0] o_sync
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} imb_sync_t;
	imb_sync_t q_ff;
	imb_sync_t nxt_q;
	always_comb begin
		nxt_q.s1 = i_async;
		nxt_q.s2 = q_ff.s1;
	end
	// Reset to released lines, matching an idle bus.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q_ff <= {4'hF};
		end else begin
			q_ff <= nxt_q;
		end
	end
	assign o_sync = q_ff.s2;
endmodule // imb_sync

// File: imb_baud.sv
// Reload-and-count-down baud generator with its tick divider.
module imb_baud (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	imb_baud_if.gen b
);
	typedef struct packed {
		logic [imb_pkg::TICK_W-1:0] div;
		logic [6:0] cnt;
		logic run;
	} imb_baud_t;
	imb_baud_t q_ff;
	imb_baud_t nxt_q;
	logic tick;
	always_comb begin
		nxt_q = q_ff;
		tick = (q_ff.div == imb_pkg::TICK_LAST);
		nxt_q.div = tick ? '0 : q_ff.div + 1'b1;
		if (b.load) begin
			nxt_q.cnt = b.reload;
			nxt_q.run = 1'b1;
		end else if (q_ff.run && tick) begin
			// A count that reached zero halts until the next reload.
			if (q_ff.cnt == 7'h00) begin
				nxt_q.run = 1'b0;
			end else begin
				nxt_q.cnt = q_ff.cnt - 7'h01;
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end
	assign b.done = q_ff.run && tick && (q_ff.cnt == 7'h00);
endmodule // imb_baud

// File: imb_master.sv
// I2C master engine: start, byte transmit, stop and register port.
// Contract
// - Master operation only with master mode encoding and port enable set.
// - Start-seen and stop-seen clear on reset and while disabled.
// - Buffer write during a running sequence is dropped, sets write collision.
// - Low five sequence bits of control two ignore writes during Start.
// - Interrupt flag sets on start, stop, byte, acknowledge, repeated start; this engine has no repeated start.
// - Transmit first byte is address with read/write bit zero.
// - Receive first byte is address with read/write bit one.
// - Bytes move eight bits, each followed by one acknowledge bit.
// - Device makes every clock pulse, Start and Stop condition.
// - Acknowledge from slave is stored in control two bit six.
// - Interrupt flag sets at end of ninth clock of each byte.
// - Stop enable bit two makes a Stop, then raises interrupt flag.
// - Baud reload is low seven bits; buffer write starts counting.
// - Baud counter counts down to zero then halts until reloaded.
// - Two baud rollovers make one clock period.
// - At end of operation baud stops and clock holds its level.
// - Baud suspends after clock release until clock is sampled high.
// - Start: both lines high at timeout, pull data low, set start-seen.
// - One more baud period, then clear start enable, hold data low.
// - Low lines or early low clock during Start flag bus collision.
module imb_master (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_o,
	output logic o_scl_oe,
	output logic o_sda_o,
	output logic o_sda_oe
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		imb_pkg::imb_state_t st;
		logic en;
		logic [3:0] mode;
		logic [7:0] con2;
		logic [7:0] baud;
		logic [7:0] xbuf;
		logic [7:0] sh;
		logic [3:0] bitn;
		logic bf;
		logic s_seen;
		logic p_seen;
		logic sif;
		logic bcl;
		logic write_collision_flag;
		logic scl_oe;
		logic sda_oe;
		logic [7:0] rdata;
	} imb_master_t;
	imb_master_t q_ff;
	imb_master_t nxt_q;
	logic [1:0] lines;
	logic scl_s;
	logic sda_s;
	logic master;
	logic free;
	logic wr_buf;
	imb_baud_if bif ();
	// ------------------------------------------------------------
	// Line sampling and baud generator
	// ------------------------------------------------------------
	imb_sync u_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_scl, i_sda}),
		.o_sync(lines)
	);
	assign scl_s = lines[1];
	assign sda_s = lines[0];
	imb_baud u_baud (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.b(bif.gen)
	);
	assign master = q_ff.en && (q_ff.mode == imb_pkg::MODE_MASTER);
	// No operation may be queued behind a pending or running one.
	assign free = (q_ff.st == imb_pkg::S_IDLE) && (q_ff.con2[4:0] == 5'h00);
	assign wr_buf = i_wr && (i_addr == imb_pkg::A_BUF);
	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_q = q_ff;
		bif.load = 1'b0;
		bif.reload = q_ff.baud[6:0];
		nxt_q.rdata = imb_pkg::RST_BYTE;
		if (i_rd) begin
			case (i_addr)
				imb_pkg::A_CON1: nxt_q.rdata = {2'h0, q_ff.en, 1'b0, q_ff.mode};
				imb_pkg::A_CON2: nxt_q.rdata = q_ff.con2;
				imb_pkg::A_STAT: begin
					nxt_q.rdata[imb_pkg::BF_BIT] = q_ff.bf;
					nxt_q.rdata[imb_pkg::SSEEN_BIT] = q_ff.s_seen;
					nxt_q.rdata[imb_pkg::PSEEN_BIT] = q_ff.p_seen;
				end
				imb_pkg::A_BAUD: nxt_q.rdata = q_ff.baud;
				imb_pkg::A_BUF: nxt_q.rdata = q_ff.xbuf;
				imb_pkg::A_FLAG: begin
					nxt_q.rdata[imb_pkg::SIF_BIT] = q_ff.sif;
					nxt_q.rdata[imb_pkg::BCL_BIT] = q_ff.bcl;
					nxt_q.rdata[imb_pkg::WRITE_COLLISION_FLAG_BIT] = q_ff.write_collision_flag;
				end
				default: nxt_q.rdata = imb_pkg::RST_BYTE;
			endcase
		end
		if (i_wr) begin
			case (i_addr)
				imb_pkg::A_CON1: begin
					nxt_q.en = i_wdata[imb_pkg::EN_BIT];
					nxt_q.mode = i_wdata[3:0];
				end
				imb_pkg::A_CON2: begin
					nxt_q.con2[imb_pkg::GCEN_BIT] = i_wdata[imb_pkg::GCEN_BIT];
					nxt_q.con2[imb_pkg::ACKDT_BIT] = i_wdata[imb_pkg::ACKDT_BIT];
					if (free) begin
						nxt_q.con2[4:0] = i_wdata[4:0];
					end
				end
				imb_pkg::A_BAUD: nxt_q.baud = i_wdata;
				imb_pkg::A_FLAG: begin
					// Write one to clear; hardware sets below win.
					if (i_wdata[imb_pkg::SIF_BIT]) begin
						nxt_q.sif = 1'b0;
					end
					if (i_wdata[imb_pkg::BCL_BIT]) begin
						nxt_q.bcl = 1'b0;
					end
					if (i_wdata[imb_pkg::WRITE_COLLISION_FLAG_BIT]) begin
						nxt_q.write_collision_flag = 1'b0;
					end
				end
				default: nxt_q.rdata = nxt_q.rdata;
			endcase
		end
		case (q_ff.st)
			imb_pkg::S_IDLE: begin
				if (master && q_ff.con2[imb_pkg::SEN_BIT]) begin
					if (!sda_s && !scl_s) begin
						nxt_q.bcl = 1'b1;
						nxt_q.con2[imb_pkg::SEN_BIT] = 1'b0;
					end else if (sda_s && scl_s) begin
						bif.load = 1'b1;
						nxt_q.st = imb_pkg::S_STA1;
					end
				end else if (master && q_ff.con2[imb_pkg::PEN_BIT]) begin
					bif.load = 1'b1;
					nxt_q.scl_oe = 1'b1;
					nxt_q.sda_oe = 1'b1;
					nxt_q.st = imb_pkg::S_PLO;
				end
			end
			imb_pkg::S_STA1: begin
				if (!scl_s) begin
					nxt_q.bcl = 1'b1;
					nxt_q.con2[imb_pkg::SEN_BIT] = 1'b0;
					nxt_q.st = imb_pkg::S_IDLE;
				end else if (bif.done) begin
					if (sda_s) begin
						nxt_q.sda_oe = 1'b1;
						nxt_q.s_seen = 1'b1;
						nxt_q.p_seen = 1'b0;
						bif.load = 1'b1;
						nxt_q.st = imb_pkg::S_STA2;
					end else begin
						nxt_q.bcl = 1'b1;
						nxt_q.con2[imb_pkg::SEN_BIT] = 1'b0;
						nxt_q.st = imb_pkg::S_IDLE;
					end
				end
			end
			imb_pkg::S_STA2: begin
				if (bif.done) begin
					nxt_q.con2[imb_pkg::SEN_BIT] = 1'b0;
					nxt_q.sif = 1'b1;
					nxt_q.st = imb_pkg::S_IDLE;
				end
			end
			imb_pkg::S_BLO: begin
				// Data moves only once SCL is low, so no false Start or Stop.
				if (q_ff.bitn == imb_pkg::ACK_SLOT) begin
					nxt_q.sda_oe = 1'b0;
				end else begin
					nxt_q.sda_oe = !q_ff.sh[7];
				end
				if (bif.done) begin
					nxt_q.scl_oe = 1'b0;
					nxt_q.st = imb_pkg::S_BWT;
				end
			end
			imb_pkg::S_BWT: begin
				// A stretched clock still gets a full high period.
				if (scl_s) begin
					bif.load = 1'b1;
					nxt_q.st = imb_pkg::S_BHI;
				end
			end
			imb_pkg::S_BHI: begin
				if (bif.done) begin
					nxt_q.scl_oe = 1'b1;
					if (q_ff.bitn == imb_pkg::ACK_SLOT) begin
						nxt_q.con2[imb_pkg::ACKST_BIT] = sda_s;
						nxt_q.sif = 1'b1;
						nxt_q.st = imb_pkg::S_IDLE;
					end else begin
						nxt_q.bitn = q_ff.bitn + imb_pkg::BIT_ONE;
						nxt_q.sh = {q_ff.sh[6:0], 1'b0};
						if (nxt_q.bitn == imb_pkg::ACK_SLOT) begin
							nxt_q.bf = 1'b0;
						end
						bif.load = 1'b1;
						nxt_q.st = imb_pkg::S_BLO;
					end
				end
			end
			imb_pkg::S_PLO: begin
				if (bif.done) begin
					nxt_q.scl_oe = 1'b0;
					nxt_q.st = imb_pkg::S_PWT;
				end
			end
			imb_pkg::S_PWT: begin
				if (scl_s) begin
					bif.load = 1'b1;
					nxt_q.st = imb_pkg::S_PHI;
				end
			end
			imb_pkg::S_PHI: begin
				if (bif.done) begin
					nxt_q.sda_oe = 1'b0;
					bif.load = 1'b1;
					nxt_q.st = imb_pkg::S_PREL;
				end
			end
			imb_pkg::S_PREL: begin
				if (bif.done) begin
					nxt_q.p_seen = 1'b1;
					nxt_q.s_seen = 1'b0;
					nxt_q.sif = 1'b1;
					nxt_q.con2[imb_pkg::PEN_BIT] = 1'b0;
					nxt_q.st = imb_pkg::S_IDLE;
				end
			end
			default: nxt_q.st = imb_pkg::S_IDLE;
		endcase
		if (wr_buf) begin
			if (free) begin
				// The byte goes out MSB first; bit 0 is the read/write bit.
				nxt_q.xbuf = i_wdata;
				nxt_q.sh = i_wdata;
				nxt_q.bf = 1'b1;
				if (master) begin
					nxt_q.bitn = 4'h0;
					nxt_q.scl_oe = 1'b1;
					bif.load = 1'b1;
					nxt_q.st = imb_pkg::S_BLO;
				end
			end else begin
				nxt_q.write_collision_flag = 1'b1;
			end
		end
		if (!master) begin
			// Leaving master mode releases the bus at once.
			nxt_q.st = imb_pkg::S_IDLE;
			nxt_q.scl_oe = 1'b0;
			nxt_q.sda_oe = 1'b0;
		end
		if (!q_ff.en) begin
			nxt_q.s_seen = 1'b0;
			nxt_q.p_seen = 1'b0;
		end
	end
	// ------------------------------------------------------------
	// Registers and outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q_ff <= '0;
			q_ff.st <= imb_pkg::S_IDLE;
		end else begin
			q_ff <= nxt_q;
		end
	end
	// Open drain: the pin is only ever pulled low or released.
	assign o_scl_o = 1'b0;
	assign o_sda_o = 1'b0;
	assign o_scl_oe = q_ff.scl_oe;
	assign o_sda_oe = q_ff.sda_oe;
	assign o_rdata = q_ff.rdata;
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_NOT_MASTER: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!master |=> !o_scl_oe && !o_sda_oe)
		else $error("bus driven outside master mode");
	AST_SEEN_CLR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!q_ff.en |=> !q_ff.s_seen && !q_ff.p_seen)
		else $error("seen bits not cleared while disabled");
	AST_WRITE_COLLISION_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		wr_buf && !free |=> q_ff.write_collision_flag && $stable(q_ff.xbuf))
		else $error("busy buffer write not rejected");
	AST_CON2_LOCK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_wr && i_addr == imb_pkg::A_CON2
		&& ((q_ff.st == imb_pkg::S_STA1 && scl_s && sda_s)
		|| (q_ff.st == imb_pkg::S_STA2 && !bif.done))
		|=> q_ff.con2[4:0] == $past(q_ff.con2[4:0]))
		else $error("sequence bits changed during start");
	AST_ACKNOWLEDGE_STATUS_BIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		q_ff.st == imb_pkg::S_BHI && bif.done && q_ff.bitn == 4'h8 && master
		|=> q_ff.con2[6] == $past(sda_s) && q_ff.sif)
		else $error("acknowledge not stored");
	AST_NINE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		wr_buf && free && master
		|=> (q_ff.st == imb_pkg::S_BLO && q_ff.bitn == 4'h0)
		##[1:1000] q_ff.bitn == 4'h8)
		else $error("byte did not reach the ninth clock");
	AST_STOP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		q_ff.st == imb_pkg::S_PREL && bif.done && master
		|=> q_ff.p_seen && q_ff.sif && !q_ff.con2[2])
		else $error("stop completion missing");
	AST_START: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		q_ff.st == imb_pkg::S_STA1 && bif.done && scl_s && sda_s && master
		|=> o_sda_oe && q_ff.s_seen && q_ff.st == imb_pkg::S_STA2)
		else $error("start edge not driven");
	AST_START_END: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		q_ff.st == imb_pkg::S_STA2 && bif.done && master
		|=> !q_ff.con2[0] && o_sda_oe && q_ff.st == imb_pkg::S_IDLE)
		else $error("start not completed");
	AST_BCL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		q_ff.st == imb_pkg::S_STA1 && !scl_s && master
		|=> q_ff.bcl && q_ff.st == imb_pkg::S_IDLE)
		else $error("collision not flagged");
	AST_ARB: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		q_ff.st == imb_pkg::S_BWT && !scl_s && master && !wr_buf
		|=> q_ff.st == imb_pkg::S_BWT)
		else $error("baud ran while clock held low");
	AST_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		q_ff.st == imb_pkg::S_IDLE && master && q_ff.con2[4:0] == 5'h00
		&& !i_wr |=> $stable(o_scl_oe))
		else $error("clock moved while idle");
endmodule // imb_master

// File: imb_slave.sv
// Behavioural I2C slave that acknowledges bytes and can stretch the clock.
module imb_slave (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_nack,
	input wire logic i_stretch,
	output logic o_scl_oe,
	output logic o_sda_oe,
	output logic [7:0] o_byte,
	output logic [3:0] o_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Bit capture
	// ------------------------------------------------------------
	initial begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
		o_byte = 8'h00;
		o_cnt = 4'h0;
	end
	// A falling data line while the clock is high restarts the count.
	always @(negedge i_sda) begin
		if (i_scl) begin
			o_cnt = 4'h0;
		end
	end
	always @(posedge i_scl) begin
		if (o_cnt == 4'h9) begin
			o_cnt = 4'h0;
		end
		o_cnt = o_cnt + 4'h1;
		if (o_cnt <= 4'h8) begin
			o_byte = {o_byte[6:0], i_sda};
		end
	end
	// ------------------------------------------------------------
	// Acknowledge and stretching
	// ------------------------------------------------------------
	// The stretch is longer than a low phase, so the master must wait.
	always @(negedge i_scl) begin
		o_sda_oe = (o_cnt == 4'h8) && !i_nack;
		if (i_stretch) begin
			o_scl_oe = 1'b1;
			#300;
			o_scl_oe = 1'b0;
		end
	end
endmodule // imb_slave

// File: imb_master_tb.sv
// Self-checking testbench of the I2C master engine.
module imb_master_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic m_scl_o, m_scl_oe, m_sda_o, m_sda_oe;
	logic s_scl_oe, s_sda_oe;
	logic [7:0] s_byte;
	logic [3:0] s_cnt;
	logic tb_low = 1'b0;
	logic nack = 1'b0;
	logic stretch = 1'b1;
	logic [7:0] d;
	logic [7:0] bytes [2] = '{8'hA4, 8'hA5};
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int k;
	// Both lines are pulled up; any party pulling low wins.
	wire scl_w = !(m_scl_oe | s_scl_oe | tb_low);
	wire sda_w = !(m_sda_oe | s_sda_oe | tb_low);
	always #12.5 i_clk = ~i_clk;
	imb_master dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_scl(scl_w), .i_sda(sda_w), .o_scl_o(m_scl_o),
		.o_scl_oe(m_scl_oe), .o_sda_o(m_sda_o), .o_sda_oe(m_sda_oe));
	imb_slave part_u (.i_scl(scl_w), .i_sda(sda_w), .i_nack(nack),
		.i_stretch(stretch), .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe),
		.o_byte(s_byte), .o_cnt(s_cnt));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask
	task rchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	// Polls the flag register under a bound so a dead engine cannot hang.
	task wait_flag(input int b);
		int i;
		logic [7:0] f;
		f = 8'h00;
		for (i = 0; i < 3000 && f[b] !== 1'b1; i++) begin
			rd(imb_pkg::A_FLAG, f);
		end
		chk({7'h0, f[b]}, 8'h01);
	endtask
	task end_of_test;
		$display("Checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			$display("[FAIL] %0t cycle limit reached", $time);
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		for (k = 0; k < 8; k++) begin
			rchk(k[2:0], 8'h00);
		end
		wr(imb_pkg::A_BAUD, 8'h01);
		rchk(imb_pkg::A_BAUD, 8'h01);
		wr(imb_pkg::A_CON1, 8'h28);
		rchk(imb_pkg::A_CON1, 8'h28);
		rchk(imb_pkg::A_STAT, 8'h00);
		chk({4'h0, m_scl_o, m_sda_o, m_scl_oe, m_sda_oe}, 8'h00);
		// Writes made while the Start runs must all be refused.
		wr(imb_pkg::A_CON2, 8'h01);
		wr(imb_pkg::A_BUF, 8'h99);
		wr(imb_pkg::A_CON2, 8'h05);
		k = 0;
		while (m_sda_oe !== 1'b1 && k < 100) begin
			@(posedge i_clk);
			k++;
		end
		chk({7'h0, (k <= 8)}, 8'h01);
		wait_flag(imb_pkg::SIF_BIT);
		rchk(imb_pkg::A_CON2, 8'h00);
		rchk(imb_pkg::A_STAT, 8'h08);
		rchk(imb_pkg::A_BUF, 8'h00);
		rchk(imb_pkg::A_FLAG, 8'h05);
		chk({6'h0, scl_w, sda_w}, 8'h02);
		wr(imb_pkg::A_FLAG, 8'h07);
		rchk(imb_pkg::A_FLAG, 8'h00);
		// Write address then read address; the second is not acknowledged.
		for (k = 0; k < 2; k++) begin
			nack <= k[0];
			wr(imb_pkg::A_BUF, bytes[k]);
			rchk(imb_pkg::A_STAT, 8'h09);
			wait_flag(imb_pkg::SIF_BIT);
			chk(s_byte, bytes[k]);
			chk({4'h0, s_cnt}, 8'h09);
			rchk(imb_pkg::A_CON2, {1'b0, k[0], 6'h00});
			chk({7'h0, scl_w}, 8'h00);
			wr(imb_pkg::A_FLAG, 8'h01);
		end
		wr(imb_pkg::A_CON2, 8'h04);
		wait_flag(imb_pkg::SIF_BIT);
		rchk(imb_pkg::A_STAT, 8'h10);
		rchk(imb_pkg::A_CON2, 8'h40);
		chk({6'h0, scl_w, sda_w}, 8'h03);
		wr(imb_pkg::A_FLAG, 8'h07);
		// Another party holds both lines low when the Start is asked for.
		stretch <= 1'b0;
		tb_low <= 1'b1;
		repeat (4) @(posedge i_clk);
		wr(imb_pkg::A_CON2, 8'h01);
		repeat (20) @(posedge i_clk);
		rchk(imb_pkg::A_FLAG, 8'h02);
		rd(imb_pkg::A_CON2, d);
		chk({7'h0, d[0]}, 8'h00);
		chk({7'h0, m_sda_oe}, 8'h00);
		@(posedge i_clk);
		tb_low <= 1'b0;
		wr(imb_pkg::A_FLAG, 8'h07);
		wr(imb_pkg::A_CON1, 8'h00);
		rchk(imb_pkg::A_STAT, 8'h00);
		end_of_test();
	end
endmodule // imb_master_tb
